// ===== logic/aspb_pkg.sv
`default_nettype none
package aspb_pkg;
	localparam int unsigned ADDR_W = 20;

	localparam logic [19:0] OFF_P1_INT  = 20'h40000;
	localparam logic [19:0] OFF_P1_CTRL = 20'h40e00;
	localparam logic [19:0] OFF_P1_AUX  = 20'h40e04;
	localparam logic [19:0] OFF_P1_RATE = 20'h40e08;
	localparam logic [19:0] OFF_P1_DATA = 20'h40e0c;
	localparam logic [19:0] OFF_P2_CTRL = 20'h40e10;
	localparam logic [19:0] OFF_P2_AUX  = 20'h40e14;
	localparam logic [19:0] OFF_P2_RATE = 20'h40e18;
	localparam logic [19:0] OFF_P2_DATA = 20'h40e1c;
	localparam logic [19:0] OFF_P2_INT  = 20'h40e20;

	// control word zero status bits
	localparam int unsigned B_OVR   = 23;
	localparam int unsigned B_NOISE = 22;
	localparam int unsigned B_FRM   = 21;
	localparam int unsigned B_PAR   = 20;
	localparam int unsigned B_XACT  = 19;
	localparam int unsigned B_XBF   = 18;
	localparam int unsigned B_RACT  = 17;
	localparam int unsigned B_RBF   = 16;
	// interrupt control word bits
	localparam int unsigned B_XIE = 19;
	localparam int unsigned B_RIE = 18;
	localparam int unsigned B_XIR = 11;
	localparam int unsigned B_RIR = 10;
	localparam int unsigned B_XIF = 3;
	localparam int unsigned B_RIF = 2;
	// auxiliary control bits, then the transmit data position in the data word
	localparam int unsigned B_WAKE = 2;
	localparam int unsigned B_PEN  = 1;
	localparam int unsigned B_ODD  = 0;
	localparam int unsigned B_TXD  = 16;

	localparam logic [7:0]  CTRL0_RST = 8'h60;
	localparam logic [15:0] RATE_RST  = 16'h0000;
	localparam logic [3:0]  MAX_BITS  = 4'h9;
	localparam logic [3:0]  BASE_BITS = 4'h6;
	// each bit is four divider ticks; start is checked at two
	localparam logic [1:0]  TICK_LAST = 2'h3;
	localparam logic [1:0]  TICK_HALF = 2'h1;

	typedef enum logic [2:0] {PH_IDLE, PH_START, PH_DATA, PH_PAR, PH_STOP}
		aspb_ph_e;

	typedef struct packed {
		logic [1:0]  stop_len;
		logic [1:0]  data_len;
		logic        rcv_irq_style;
		logic        rcv_en;
		logic        xmt_irq_style;
		logic        xmt_en;
		logic        parity_enable;
		logic        odd_parity_select;
		logic        rcv_wake_enable;
		logic [15:0] divisor;
	} aspb_cfg_s;

	typedef struct packed {
		logic       overrun_error;
		logic       noise_error;
		logic       framing_error;
		logic       parity_error;
		logic       xmt_active;
		logic       xmt_buffer_full;
		logic       rcv_active;
		logic       rcv_buffer_full;
		logic       xmt_irq_flag;
		logic       rcv_irq_flag;
		logic       rcv_done;
		logic [8:0] rcv_data;
	} aspb_stat_s;
endpackage
`default_nettype wire

// ===== logic/aspb_top.sv
// How it works
// - a read of the data word empties the receive buffer unless a frame completes in that cycle
// - receive enable clear: flag sets, request stays low
// - receive enable set: flag and request both rise, vector taken
// - clearing the receive flag drops its request at once
// - transmit write sets buffer full; move to shifter clears it
// - word waits in buffer while shifter still sends
// - write to a full transmit buffer overwrites the held word
// - transmit style zero: flag is inverse of buffer full
// - transmit style one: flag set after stop, cleared by software
// - receiver busy half a bit after start; buffer full stays low
// - at stop: busy clears, buffer full and receive flag set
// - receive style zero: flag clear needs a data read first
// - receive style one: flag clears directly by software
// - wake enable: first frame in sleep wakes chip, raises flag
// - overrun, noise, framing, parity at bits 23 to 20
// - port one on vector zero, port two on vector seven
// - bit rate is clock over four times divisor plus one
// - parity odd when select is one, even otherwise; checked
`timescale 1ns/1ps
`default_nettype none

module aspb_chan (
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	input  wire aspb_pkg::aspb_cfg_s cfg,
	input  wire logic               tx_wr,
	input  wire logic [8:0]         tx_wdata,
	input  wire logic               rx_rd,
	input  wire logic [3:0]         err_clr,
	input  wire logic               rif_clr,
	input  wire logic               xif_clr,
	input  wire logic               rxd,
	output aspb_pkg::aspb_stat_s    stat,
	output logic                    txd
);
	aspb_pkg::aspb_ph_e tx_ph_r, rx_ph_r;
	logic [15:0] tx_div_r, rx_div_r;
	logic [1:0]  tx_q_r, rx_q_r;
	logic [2:0]  tx_stop_r;
	logic [3:0]  tx_bit_r, rx_bit_r;
	logic [8:0]  tx_sh_r, tx_buf_r, rx_sh_r, rx_buf_r;
	logic        tx_par_r, rx_par_r, rx_prev_r, rx_mid_r;
	logic        xbf_r, xif_r, rbf_r, rif_r, ract_r, rd_seen_r, done_r;
	logic        ovr_r, noise_r, frm_r, parity_error_r, txd_r;
	logic [3:0]  nbits;
	logic [2:0]  stop_last;
	logic        tx_tick, rx_tick, tx_bit_end, rx_center, tx_load;

	// parity eats one of the data-length slots
	assign nbits     = aspb_pkg::BASE_BITS + {2'h0, cfg.data_len}
	                   - {3'h0, cfg.parity_enable};
	// stop period in ticks: 2, 4, 6 or 8 for 0.5 .. 2 bits
	assign stop_last = {cfg.stop_len, 1'b1};
	assign tx_tick    = (tx_div_r == cfg.divisor);
	assign rx_tick    = (rx_div_r == cfg.divisor);
	assign tx_bit_end = tx_tick && (tx_q_r == aspb_pkg::TICK_LAST);
	assign rx_center  = rx_tick && (rx_q_r == aspb_pkg::TICK_LAST);
	assign tx_load    = (tx_ph_r == aspb_pkg::PH_IDLE) && xbf_r
	                    && cfg.xmt_en;

	// divider restarts with each frame so the start bit is full length
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_div_r <= 16'h0000;
			tx_q_r   <= 2'h0;
		end else if (tx_load || tx_tick) begin
			tx_div_r <= 16'h0000;
			tx_q_r   <= tx_load ? 2'h0 : tx_q_r + 2'h1;
		end else begin
			tx_div_r <= tx_div_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			xbf_r    <= 1'b0;
			tx_buf_r <= 9'h000;
		end else if (tx_wr) begin
			xbf_r    <= 1'b1;
			tx_buf_r <= tx_wdata;
		end else if (tx_load) begin
			xbf_r    <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ph_r   <= aspb_pkg::PH_IDLE;
			tx_sh_r   <= 9'h000;
			tx_bit_r  <= 4'h0;
			tx_par_r  <= 1'b0;
			tx_stop_r <= 3'h0;
			txd_r     <= 1'b1;
		end else begin
			case (tx_ph_r)
			aspb_pkg::PH_IDLE: begin
				if (tx_load) begin
					tx_sh_r  <= tx_buf_r;
					txd_r    <= 1'b0;
					tx_ph_r  <= aspb_pkg::PH_START;
				end
			end
			aspb_pkg::PH_START: begin
				if (tx_bit_end) begin
					txd_r    <= tx_sh_r[0];
					tx_par_r <= tx_sh_r[0];
					tx_sh_r  <= tx_sh_r >> 1;
					tx_bit_r <= 4'h0;
					tx_ph_r  <= aspb_pkg::PH_DATA;
				end
			end
			aspb_pkg::PH_DATA: begin
				if (tx_bit_end) begin
					if (tx_bit_r == nbits - 4'h1) begin
						tx_stop_r <= 3'h0;
						if (cfg.parity_enable) begin
							txd_r   <= tx_par_r ^ cfg.odd_parity_select;
							tx_ph_r <= aspb_pkg::PH_PAR;
						end else begin
							txd_r   <= 1'b1;
							tx_ph_r <= aspb_pkg::PH_STOP;
						end
					end else begin
						txd_r    <= tx_sh_r[0];
						tx_par_r <= tx_par_r ^ tx_sh_r[0];
						tx_sh_r  <= tx_sh_r >> 1;
						tx_bit_r <= tx_bit_r + 4'h1;
					end
				end
			end
			aspb_pkg::PH_PAR: begin
				if (tx_bit_end) begin
					txd_r   <= 1'b1;
					tx_ph_r <= aspb_pkg::PH_STOP;
				end
			end
			aspb_pkg::PH_STOP: begin
				if (tx_tick) begin
					tx_stop_r <= tx_stop_r + 3'h1;
					if (tx_stop_r == stop_last)
						tx_ph_r <= aspb_pkg::PH_IDLE;
				end
			end
			default: tx_ph_r <= aspb_pkg::PH_IDLE;
			endcase
		end
	end

	// style one flag; set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			xif_r <= 1'b0;
		else if (tx_ph_r == aspb_pkg::PH_STOP && tx_tick
		         && tx_stop_r == stop_last)
			xif_r <= 1'b1;
		else if (xif_clr)
			xif_r <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_div_r <= 16'h0000;
			rx_q_r   <= 2'h0;
		end else if (rx_ph_r == aspb_pkg::PH_IDLE) begin
			rx_div_r <= 16'h0000;
			rx_q_r   <= 2'h0;
		end else if (rx_tick) begin
			rx_div_r <= 16'h0000;
			rx_q_r   <= (rx_ph_r == aspb_pkg::PH_START
			             && rx_q_r == aspb_pkg::TICK_HALF)
			            ? 2'h0 : rx_q_r + 2'h1;
		end else begin
			rx_div_r <= rx_div_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_ph_r   <= aspb_pkg::PH_IDLE;
			rx_prev_r <= 1'b1;
			rx_mid_r  <= 1'b1;
			rx_sh_r   <= 9'h000;
			rx_bit_r  <= 4'h0;
			rx_par_r  <= 1'b0;
			ract_r    <= 1'b0;
			done_r    <= 1'b0;
		end else begin
			rx_prev_r <= rxd;
			done_r    <= 1'b0;
			if (rx_tick && rx_q_r == 2'h2)
				rx_mid_r <= rxd;
			case (rx_ph_r)
			aspb_pkg::PH_IDLE: begin
				if (cfg.rcv_en && rx_prev_r && !rxd)
					rx_ph_r <= aspb_pkg::PH_START;
			end
			aspb_pkg::PH_START: begin
				if (rx_tick && rx_q_r == aspb_pkg::TICK_HALF) begin
					if (!rxd) begin
						ract_r   <= 1'b1;
						rx_bit_r <= 4'h0;
						rx_par_r <= 1'b0;
						rx_ph_r  <= aspb_pkg::PH_DATA;
					end else begin
						rx_ph_r  <= aspb_pkg::PH_IDLE;
					end
				end
			end
			aspb_pkg::PH_DATA: begin
				if (rx_center) begin
					rx_sh_r  <= {rxd, rx_sh_r[8:1]};
					rx_par_r <= rx_par_r ^ rxd;
					rx_bit_r <= rx_bit_r + 4'h1;
					if (rx_bit_r == nbits - 4'h1)
						rx_ph_r <= cfg.parity_enable ? aspb_pkg::PH_PAR
						                             : aspb_pkg::PH_STOP;
				end
			end
			aspb_pkg::PH_PAR: begin
				if (rx_center)
					rx_ph_r <= aspb_pkg::PH_STOP;
			end
			aspb_pkg::PH_STOP: begin
				if (rx_center) begin
					ract_r  <= 1'b0;
					done_r  <= 1'b1;
					rx_ph_r <= aspb_pkg::PH_IDLE;
				end
			end
			default: rx_ph_r <= aspb_pkg::PH_IDLE;
			endcase
		end
	end

	logic stop_hit, par_hit, data_hit;
	assign stop_hit = rx_center && rx_ph_r == aspb_pkg::PH_STOP;
	assign par_hit  = rx_center && rx_ph_r == aspb_pkg::PH_PAR;
	assign data_hit = rx_center && rx_ph_r == aspb_pkg::PH_DATA;

	// buffer and flags; a completing frame beats a same-cycle read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rbf_r     <= 1'b0;
			rx_buf_r  <= 9'h000;
			rif_r     <= 1'b0;
			rd_seen_r <= 1'b0;
		end else begin
			if (stop_hit) begin
				rbf_r     <= 1'b1;
				rif_r     <= 1'b1;
				rd_seen_r <= 1'b0;
				rx_buf_r  <= rx_sh_r >> (aspb_pkg::MAX_BITS - nbits);
			end else begin
				if (rx_rd) begin
					rbf_r     <= 1'b0;
					rd_seen_r <= 1'b1;
				end
				if (rif_clr && (cfg.rcv_irq_style || rd_seen_r))
					rif_r <= 1'b0;
			end
		end
	end

	// error bits clear where software writes zero; a new error wins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovr_r   <= 1'b0;
			noise_r <= 1'b0;
			frm_r   <= 1'b0;
			parity_error_r  <= 1'b0;
		end else begin
			if (stop_hit && rbf_r && !rx_rd)
				ovr_r <= 1'b1;
			else if (err_clr[3])
				ovr_r <= 1'b0;
			if ((data_hit || par_hit || stop_hit) && rxd != rx_mid_r)
				noise_r <= 1'b1;
			else if (err_clr[2])
				noise_r <= 1'b0;
			if (stop_hit && !rxd)
				frm_r <= 1'b1;
			else if (err_clr[1])
				frm_r <= 1'b0;
			if (par_hit && rxd != (rx_par_r ^ cfg.odd_parity_select))
				parity_error_r <= 1'b1;
			else if (err_clr[0])
				parity_error_r <= 1'b0;
		end
	end

	assign txd = txd_r;
	always_comb begin
		stat.overrun_error   = ovr_r;
		stat.noise_error     = noise_r;
		stat.framing_error   = frm_r;
		stat.parity_error    = parity_error_r;
		stat.xmt_active      = (tx_ph_r != aspb_pkg::PH_IDLE);
		stat.xmt_buffer_full = xbf_r;
		stat.rcv_active      = ract_r;
		stat.rcv_buffer_full = rbf_r;
		stat.xmt_irq_flag    = cfg.xmt_irq_style ? xif_r : !xbf_r;
		stat.rcv_irq_flag    = rif_r;
		stat.rcv_done        = done_r;
		stat.rcv_data        = rx_buf_r;
	end
endmodule

module aspb_top (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [19:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rxd1,
	output logic             txd1,
	input  wire logic        rxd2,
	output logic             txd2,
	input  wire logic        sleep_mode,
	output logic             wake_req,
	output logic             vector_zero,
	output logic             vector_seven
);
	aspb_pkg::aspb_cfg_s  cfg1_r, cfg2_r;
	aspb_pkg::aspb_stat_s st1, st2;
	logic xie1_r, rie1_r, xie2_r, rie2_r;
	logic pready_r, pslverr_r, wake_r, vz_r, vs_r;
	logic [31:0] prdata_r, rd_mux;
	logic acc, wr, rd, hit;
	logic txd1_i, txd2_i, txd1_r, txd2_r;

	// read answer is built in the first access cycle, given in the second
	assign acc = psel && penable && pready_r;
	assign wr  = acc && pwrite;
	assign rd  = acc && !pwrite;

	function automatic logic [31:0] ctrl_word(aspb_pkg::aspb_cfg_s c,
	                                          aspb_pkg::aspb_stat_s s);
		ctrl_word = {8'h00, s.overrun_error, s.noise_error,
		             s.framing_error, s.parity_error, s.xmt_active,
		             s.xmt_buffer_full, s.rcv_active, s.rcv_buffer_full,
		             8'h00, c.stop_len, c.data_len, c.rcv_irq_style,
		             c.rcv_en, c.xmt_irq_style, c.xmt_en};
	endfunction

	function automatic logic [31:0] int_word(logic xie, logic rie,
	                                         aspb_pkg::aspb_stat_s s);
		int_word = 32'h00000000;
		int_word[aspb_pkg::B_XIE] = xie;
		int_word[aspb_pkg::B_RIE] = rie;
		int_word[aspb_pkg::B_XIR] = xie && s.xmt_irq_flag;
		int_word[aspb_pkg::B_RIR] = rie && s.rcv_irq_flag;
		int_word[aspb_pkg::B_XIF] = s.xmt_irq_flag;
		int_word[aspb_pkg::B_RIF] = s.rcv_irq_flag;
	endfunction

	function automatic logic [31:0] aux_word(aspb_pkg::aspb_cfg_s c);
		aux_word = {29'h00000000, c.rcv_wake_enable, c.parity_enable,
		            c.odd_parity_select};
	endfunction

	always_comb begin
		hit = 1'b1;
		case (paddr)
		aspb_pkg::OFF_P1_INT:  rd_mux = int_word(xie1_r, rie1_r, st1);
		aspb_pkg::OFF_P1_CTRL: rd_mux = ctrl_word(cfg1_r, st1);
		aspb_pkg::OFF_P1_AUX:  rd_mux = aux_word(cfg1_r);
		aspb_pkg::OFF_P1_RATE: rd_mux = {16'h0000, cfg1_r.divisor};
		aspb_pkg::OFF_P1_DATA: rd_mux = {23'h000000, st1.rcv_data};
		aspb_pkg::OFF_P2_CTRL: rd_mux = ctrl_word(cfg2_r, st2);
		aspb_pkg::OFF_P2_AUX:  rd_mux = aux_word(cfg2_r);
		aspb_pkg::OFF_P2_RATE: rd_mux = {16'h0000, cfg2_r.divisor};
		aspb_pkg::OFF_P2_DATA: rd_mux = {23'h000000, st2.rcv_data};
		aspb_pkg::OFF_P2_INT:  rd_mux = int_word(xie2_r, rie2_r, st2);
		default: begin
			rd_mux = 32'h00000000;
			hit    = 1'b0;
		end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= psel && penable && !pready_r;
			pslverr_r <= psel && penable && !pready_r && !hit;
			prdata_r  <= (psel && penable && !pready_r && !pwrite)
			             ? rd_mux : 32'h00000000;
		end
	end

	function automatic aspb_pkg::aspb_cfg_s cfg_rst();
		cfg_rst = '0;
		{cfg_rst.stop_len, cfg_rst.data_len} = aspb_pkg::CTRL0_RST[7:4];
		cfg_rst.divisor = aspb_pkg::RATE_RST;
	endfunction

	// software owns setup order; hardware takes each field as written
	function automatic aspb_pkg::aspb_cfg_s cfg_upd(
		aspb_pkg::aspb_cfg_s c, logic [1:0] sel, logic [31:0] d);
		cfg_upd = c;
		case (sel)
		2'h0: {cfg_upd.stop_len, cfg_upd.data_len, cfg_upd.rcv_irq_style,
		       cfg_upd.rcv_en, cfg_upd.xmt_irq_style, cfg_upd.xmt_en}
		      = d[7:0];
		2'h1: begin
			cfg_upd.rcv_wake_enable   = d[aspb_pkg::B_WAKE];
			cfg_upd.parity_enable     = d[aspb_pkg::B_PEN];
			cfg_upd.odd_parity_select = d[aspb_pkg::B_ODD];
		end
		2'h2: cfg_upd.divisor = d[15:0];
		default: cfg_upd = c;
		endcase
	endfunction

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg1_r <= cfg_rst();
			cfg2_r <= cfg_rst();
		end else if (wr && paddr[19:5] == aspb_pkg::OFF_P1_CTRL[19:5]
		             && paddr[1:0] == 2'h0 && paddr[3:2] != 2'h3) begin
			if (paddr[4])
				cfg2_r <= cfg_upd(cfg2_r, paddr[3:2], pwdata);
			else
				cfg1_r <= cfg_upd(cfg1_r, paddr[3:2], pwdata);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			xie1_r <= 1'b0;
			rie1_r <= 1'b0;
			xie2_r <= 1'b0;
			rie2_r <= 1'b0;
		end else if (wr && paddr == aspb_pkg::OFF_P1_INT) begin
			xie1_r <= pwdata[aspb_pkg::B_XIE];
			rie1_r <= pwdata[aspb_pkg::B_RIE];
		end else if (wr && paddr == aspb_pkg::OFF_P2_INT) begin
			xie2_r <= pwdata[aspb_pkg::B_XIE];
			rie2_r <= pwdata[aspb_pkg::B_RIE];
		end
	end

	logic wr_i1, wr_i2, wr_c1, wr_c2;
	assign wr_i1 = wr && paddr == aspb_pkg::OFF_P1_INT;
	assign wr_i2 = wr && paddr == aspb_pkg::OFF_P2_INT;
	assign wr_c1 = wr && paddr == aspb_pkg::OFF_P1_CTRL;
	assign wr_c2 = wr && paddr == aspb_pkg::OFF_P2_CTRL;

	aspb_chan u_port1 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.cfg      (cfg1_r),
		.tx_wr    (wr && paddr == aspb_pkg::OFF_P1_DATA),
		.tx_wdata (pwdata[aspb_pkg::B_TXD +: 9]),
		.rx_rd    (rd && paddr == aspb_pkg::OFF_P1_DATA),
		.err_clr  ({4{wr_c1}} & ~pwdata[23:20]),
		.rif_clr  (wr_i1 && !pwdata[aspb_pkg::B_RIF]),
		.xif_clr  (wr_i1 && !pwdata[aspb_pkg::B_XIF]),
		.rxd      (rxd1),
		.stat     (st1),
		.txd      (txd1_i)
	);

	aspb_chan u_port2 (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.cfg      (cfg2_r),
		.tx_wr    (wr && paddr == aspb_pkg::OFF_P2_DATA),
		.tx_wdata (pwdata[aspb_pkg::B_TXD +: 9]),
		.rx_rd    (rd && paddr == aspb_pkg::OFF_P2_DATA),
		.err_clr  ({4{wr_c2}} & ~pwdata[23:20]),
		.rif_clr  (wr_i2 && !pwdata[aspb_pkg::B_RIF]),
		.xif_clr  (wr_i2 && !pwdata[aspb_pkg::B_XIF]),
		.rxd      (rxd2),
		.stat     (st2),
		.txd      (txd2_i)
	);

	// requests are flag and enable together, so a cleared flag drops it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			vz_r   <= 1'b0;
			vs_r   <= 1'b0;
			wake_r <= 1'b0;
			txd1_r <= 1'b1;
			txd2_r <= 1'b1;
		end else begin
			vz_r <= (rie1_r && st1.rcv_irq_flag)
			        || (xie1_r && st1.xmt_irq_flag);
			vs_r <= (rie2_r && st2.rcv_irq_flag)
			        || (xie2_r && st2.xmt_irq_flag);
			// first frame in sleep wakes the chip and is still buffered; its data stays readable
			if (!sleep_mode)
				wake_r <= 1'b0;
			else if ((st1.rcv_done && cfg1_r.rcv_wake_enable)
			         || (st2.rcv_done && cfg2_r.rcv_wake_enable))
				wake_r <= 1'b1;
			txd1_r <= txd1_i;
			txd2_r <= txd2_i;
		end
	end

	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign prdata       = prdata_r;
	assign vector_zero  = vz_r;
	assign vector_seven = vs_r;
	assign wake_req     = wake_r;
	assign txd1         = txd1_r;
	assign txd2         = txd2_r;
endmodule
`default_nettype wire

// ===== verification/aspb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module aspb_monitor (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        txd1,
	input wire logic        txd2,
	input wire logic        sleep_mode,
	input wire logic        wake_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_ONE_WAIT: assert property (psel && $rose(penable) |=> pready)
		else $error("answer not after exactly one wait state");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	AST_DATA_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero between answers");
	// every low run on the line lasts at least four clock cycles, one bit only at divisor zero
	AST_TXD1_BIT: assert property ($fell(txd1) |=> !txd1 [*3])
		else $error("port one low run shorter than a bit");
	AST_TXD2_BIT: assert property ($fell(txd2) |=> !txd2 [*3])
		else $error("port two low run shorter than a bit");
	AST_WAKE_CAUSE: assert property ($rose(wake_req) |-> $past(sleep_mode))
		else $error("wake raised outside sleep");
	AST_WAKE_DROP: assert property (!sleep_mode |=> !wake_req)
		else $error("wake held after sleep ended");
endmodule
bind aspb_top aspb_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .txd1(txd1), .txd2(txd2), .sleep_mode(sleep_mode),
	.wake_req(wake_req));
`default_nettype wire

// ===== verification/aspb_host.sv
`timescale 1ns/1ps
`default_nettype none
module aspb_host #(
	parameter int BIT = 8
) (
	input  wire logic core_clk,
	input  wire logic txd,
	output var logic  rxd
);
	logic [7:0] got[$];
	logic [7:0] w;
	// the line is pulled high, so idle really reads 1
	initial rxd = 1'b1;
	task automatic send(input logic [9:0] f);
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge core_clk);
		end
		rxd <= 1'b1;
	endtask
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge core_clk);
		if (txd === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge core_clk);
				w[i] = txd;
			end
			got.push_back(w);
		end
	end
endmodule
`default_nettype wire

// ===== verification/async_serial_port_buffers_irq_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_buffers_irq_test;
	localparam logic [19:0] P1C = aspb_pkg::OFF_P1_CTRL;
	localparam logic [19:0] P1A = aspb_pkg::OFF_P1_AUX;
	localparam logic [19:0] P1D = aspb_pkg::OFF_P1_DATA;
	localparam logic [19:0] I1  = aspb_pkg::OFF_P1_INT;
	localparam logic [19:0] P2C = aspb_pkg::OFF_P2_CTRL;
	localparam logic [19:0] P2D = aspb_pkg::OFF_P2_DATA;
	localparam logic [19:0] I2  = aspb_pkg::OFF_P2_INT;
	logic        core_clk, rst_n, psel, penable, pwrite, sleep_mode;
	logic [19:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        pready, pslverr, e, rxd1, txd1, rxd2, txd2;
	logic        wake_req, vector_zero, vector_seven;
	int          failures, n_checks;
	aspb_top uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .rxd1(rxd1),
		.txd1(txd1), .rxd2(rxd2), .txd2(txd2), .sleep_mode(sleep_mode),
		.wake_req(wake_req), .vector_zero(vector_zero),
		.vector_seven(vector_seven));
	aspb_host h1 (.core_clk(core_clk), .txd(txd1), .rxd(rxd1));
	aspb_host h2 (.core_clk(core_clk), .txd(txd2), .rxd(rxd2));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic stop_test;
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask
	// idle cycle at the end keeps psel from being driven twice in one step
	task automatic apb(input logic w, input logic [19:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) failures++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [19:0] a,
		input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(nm, x, r & m);
	endtask
	task automatic poll(input logic [19:0] a, input int b, input logic v);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h0);
			k++;
		end while (r[b] !== v && k < 300);
		if (k >= 300) failures++;
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		stop_test;
	end
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 20'h0;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		failures = 0;
		n_checks = 0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rdc("ctrl0", P1C, 32'hffffffff, 32'h60);
		rdc("intctl", I1, 32'hffffffff, 32'h8);
		apb(1'b0, 20'h40e24, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		chk("bad rd", 32'h0, r);
		for (int p = 0; p < 2; p++) begin
			wr(p ? aspb_pkg::OFF_P2_RATE : aspb_pkg::OFF_P1_RATE, 32'h1);
			wr(p ? P2C : P1C, 32'h65);
		end
		fork
			h1.send({1'b1, 8'ha5, 1'b0});
			begin
				repeat (12) @(posedge core_clk);
				rdc("rx busy", P1C, 32'h30000, 32'h20000);
			end
		join
		poll(P1C, aspb_pkg::B_RBF, 1'b1);
		rdc("rx done", P1C, 32'h30000, 32'h10000);
		rdc("rx flag", I1, 32'h40c, 32'hc);
		chk("vec0", 32'h0, {31'h0, vector_zero});
		wr(I1, 32'h8);
		rdc("no clear", I1, 32'h4, 32'h4);
		rdc("rx data", P1D, 32'hffffffff, 32'ha5);
		rdc("emptied", P1C, 32'h10000, 32'h0);
		wr(I1, 32'h8);
		rdc("cleared", I1, 32'h4, 32'h0);
		wr(P1C, 32'h6d);
		wr(I1, 32'h4000c);
		h1.send({1'b1, 8'h3c, 1'b0});
		poll(I1, aspb_pkg::B_RIR, 1'b1);
		chk("vec0 on", 32'h1, {31'h0, vector_zero});
		wr(I1, 32'h40008);
		rdc("direct clr", I1, 32'h404, 32'h0);
		chk("vec0 off", 32'h0, {31'h0, vector_zero});
		rdc("rx data2", P1D, 32'h1ff, 32'h3c);
		wr(I1, 32'h8);
		wr(P1C, 32'h65);
		wr(P1D, 32'h5a0000);
		wr(P1D, 32'h810000);
		rdc("held", P1C, 32'hc0000, 32'hc0000);
		rdc("xif low", I1, 32'h8, 32'h0);
		wr(P1D, 32'h3c0000);
		poll(P1C, aspb_pkg::B_XBF, 1'b0);
		rdc("xif high", I1, 32'h8, 32'h8);
		poll(P1C, aspb_pkg::B_XACT, 1'b0);
		chk("frames", 32'h2, 32'(h1.got.size()));
		chk("frame a", 32'h5a, {24'h0, h1.got[0]});
		chk("frame c", 32'h3c, {24'h0, h1.got[1]});
		wr(P1C, 32'h67);
		wr(I1, 32'h0);
		wr(P1D, 32'h770000);
		rdc("xif wait", I1, 32'h8, 32'h0);
		poll(I1, aspb_pkg::B_XIF, 1'b1);
		rdc("xif holds", I1, 32'h8, 32'h8);
		wr(I1, 32'h0);
		rdc("xif clr", I1, 32'h8, 32'h0);
		chk("frame d", 32'h77, {24'h0, h1.got[2]});
		wr(P1C, 32'h65);
		h1.send({1'b0, 8'h11, 1'b0});
		poll(P1C, aspb_pkg::B_RBF, 1'b1);
		rdc("frame err", P1C, 32'h200000, 32'h200000);
		h1.send({1'b1, 8'h22, 1'b0});
		rdc("overrun", P1C, 32'h800000, 32'h800000);
		rdc("ovr data", P1D, 32'h1ff, 32'h22);
		wr(P1C, 32'h65);
		rdc("err clr", P1C, 32'hf00000, 32'h0);
		// nine data bits; the idle level after the call is the stop bit
		wr(P1C, 32'h75);
		h1.send({9'h1a5, 1'b0});
		poll(P1C, aspb_pkg::B_RBF, 1'b1);
		rdc("nine bits", P1D, 32'h1ff, 32'h1a5);
		wr(P1C, 32'h65);
		wr(P1A, 32'h2);
		h1.send({1'b1, 1'b0, 7'h01, 1'b0});
		rdc("even bad", P1C, 32'h100000, 32'h100000);
		rdc("par data", P1D, 32'h1ff, 32'h1);
		wr(P1A, 32'h3);
		wr(P1C, 32'h65);
		h1.send({1'b1, 1'b0, 7'h01, 1'b0});
		rdc("odd ok", P1C, 32'h100000, 32'h0);
		rdc("par data2", P1D, 32'h1ff, 32'h1);
		wr(I2, 32'h4000c);
		wr(P2D, 32'h990000);
		h2.send({1'b1, 8'h42, 1'b0});
		poll(I2, aspb_pkg::B_RIR, 1'b1);
		chk("vectors", 32'h2, {30'h0, vector_seven, vector_zero});
		rdc("p2 data", P2D, 32'h1ff, 32'h42);
		poll(P2C, aspb_pkg::B_XACT, 1'b0);
		chk("p2 frame", 32'h99, {24'h0, h2.got[0]});
		wr(I1, 32'h8);
		wr(P1A, 32'h4);
		sleep_mode <= 1'b1;
		h1.send({1'b1, 8'h05, 1'b0});
		chk("wake", 32'h1, {31'h0, wake_req});
		rdc("wake flag", I1, 32'h4, 32'h4);
		rdc("wake data", P1D, 32'h1ff, 32'h05);
		sleep_mode <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("wake off", 32'h0, {31'h0, wake_req});
		// recovery wait scaled far down to keep the run short
		repeat (64) @(posedge core_clk);
		h1.send({1'b1, 8'h6e, 1'b0});
		rdc("after wake", P1D, 32'h1ff, 32'h6e);
		stop_test;
	end
endmodule
`default_nettype wire
